//--- shared/disk_ports_pkg.sv
// Package for the disk control and status port bank.
// Assumes an 8-bit ISA-style I/O bus with separate read and write strobes.
package disk_ports_pkg;

    // Port addresses, primary and secondary set
    localparam logic [9:0] ADDR_DOR_PRI  = 10'h3f2;
    localparam logic [9:0] ADDR_MSR_PRI  = 10'h3f4;
    localparam logic [9:0] ADDR_CTL_PRI  = 10'h3f6;
    localparam logic [9:0] ADDR_DIR_PRI  = 10'h3f7;
    localparam logic [9:0] ADDR_DOR_SEC  = 10'h372;
    localparam logic [9:0] ADDR_MSR_SEC  = 10'h374;
    localparam logic [9:0] ADDR_CTL_SEC  = 10'h376;
    localparam logic [9:0] ADDR_DIR_SEC  = 10'h377;

    // Digital output register fields
    localparam int DOR_UNIT    = 0;
    localparam int DOR_RESET_N = 2;
    localparam int DOR_GATE    = 3;
    localparam int DOR_MOTOR_A = 4;
    localparam int DOR_MOTOR_B = 5;

    // Fixed disk control fields
    localparam int CTL_MASK    = 1;
    localparam int CTL_RESET   = 2;
    localparam int CTL_TOP_HEAD_SELECT_ENABLE   = 3;

    // Reset values
    localparam logic [7:0] DOR_RESET_VAL  = 8'h00;
    localparam logic       MASK_RESET_VAL = 1'b1;

    // Floppy rate codes
    typedef enum logic [1:0] {
        RATE_500_MFM = 2'b00,
        RATE_300_MFM = 2'b01,
        RATE_250_MFM = 2'b10,
        RATE_125_FM  = 2'b11
    } rate_code_t;

    // Clock and floppy reset pulse timing
    localparam int CLK_HZ          = 20_000_000;
    localparam int FLOPPY_CTRL_RESET_N_TIME_NS    = 3500;
    localparam int FLOPPY_CTRL_RESET_N_CYCLES     = (FLOPPY_CTRL_RESET_N_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int FLOPPY_CTRL_RESET_N_CNT_W      = 8;

    // Floppy controller core status
    typedef struct packed {
        logic port_ready;
        logic transfer_direction;
        logic exec_phase;
        logic cmd_active;
        logic unit_b_seeking;
        logic unit_a_seeking;
    } floppy_status_t;

    // Fixed disk status from formatter and selected drive
    typedef struct packed {
        logic busy;
        logic ready;
        logic write_fault;
        logic seek_complete;
        logic data_request;
        logic corrected_data;
        logic index_pulse;
        logic error;
    } disk_status_t;

    // Drive control lines driven by the formatter
    typedef struct packed {
        logic       write_gate;
        logic [3:0] head_select;
        logic [1:0] drive_select;
    } drive_lines_t;

endpackage : disk_ports_pkg

//--- hw/disk_ctrl_status_ports.sv
// Control and status port bank of a combined hard disk and floppy board.
// Assumes the host I/O bus strobes are already synchronous to clk.
//
// Notes on behaviour
// - Motor bit zero stops drive, blocks selection
// - Request gate passes floppy DMA, interrupt
// - Reset bit zero holds floppy controller reset
// - Unit bit picks A or B, needs motor
// - Port ready bit shows data register ready
// - Direction bit zero host-to-floppy, one reverse
// - Execution bit only in non-DMA execution
// - Command active during read or write
// - Seek bits per drive B and A
// - Alternate status mirrors formatter status, not drive lines
// - Corrected data bit from microcontroller
// - Error bit from microcontroller, cause elsewhere
// - Enable bit allows fourth head select line
// - Reset bit resets formatter, drives board reset
// - Firmware disable keeps reset to formatter only
// - Mask bit one blocks IRQ14, zero passes
// - Masking keeps pending interrupt, shows when unmasked
// - Master reset clears pending, leaves masked
// - Media change bit comes from floppy section
// - Low seven input bits mirror live drive control lines
// - Rate code picks transfer rate and encoding
// - Rate defaults to 500 kbps MFM
// - Shared addresses split reads and writes
// - Jumper picks primary or secondary addresses
// - Single byte accesses on low lanes
`timescale 1ns/1ps

module disk_ctrl_status_ports
    import disk_ports_pkg::*;
(
    input  wire logic           clk,               // 20 MHz board clock
    input  wire logic           rst_n,             // System master reset
    input  wire logic [9:0]     io_addr,           // Host I/O address
    input  wire logic           io_rd,             // Host read strobe, one cycle
    input  wire logic           io_wr,             // Host write strobe, one cycle
    input  wire logic [7:0]     io_wdata,          // Host write data, low lane
    output logic      [7:0]     io_rdata,          // Host read data, low lane
    output logic                io_rdata_en,       // Read data driven this cycle
    input  wire logic           addr_secondary,    // Jumper: secondary set
    input  wire floppy_status_t floppy_status,     // Floppy core status
    input  wire logic           floppy_irq_req,    // Floppy interrupt request
    input  wire logic           floppy_dma_req,    // Floppy DMA request
    input  wire logic           media_change_raw,  // Media change, from floppy
    input  wire disk_status_t   disk_status,       // Formatter status
    input  wire drive_lines_t   drive_lines,       // Formatter drive outputs
    input  wire logic           disk_irq_event,    // Formatter interrupt pulse
    input  wire logic           disk_irq_clear,    // Host read of status, pulse
    input  wire logic           reset_out_disable, // Firmware disabled reset out
    output logic                floppy_irq_out,    // Floppy interrupt to host
    output logic                floppy_dma_out,    // Floppy DMA request to host
    output logic                floppy_irq_oe_n,   // Low while driving irq
    output logic                floppy_dma_oe_n,   // Low while driving DMA
    output logic                floppy_ctrl_reset_n, // Floppy core reset
    output logic                floppy_motor_a_on, // Drive A motor
    output logic                floppy_motor_b_on, // Drive B motor
    output logic                floppy_sel_a,      // Drive A selected
    output logic                floppy_sel_b,      // Drive B selected
    output rate_code_t          floppy_rate,       // Rate and encoding
    output logic                formatter_reset,   // Formatter reset
    output logic                board_reset_out,   // Board reset output
    output logic                top_head_select_enable, // Fourth head line on
    output logic                host_irq14         // Hard disk interrupt
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode
    ////////////////////////////////////////////////////////////////////////////

    // Jumper picks which address set answers
    wire [9:0] a_dor = addr_secondary ? ADDR_DOR_SEC : ADDR_DOR_PRI;
    wire [9:0] a_msr = addr_secondary ? ADDR_MSR_SEC : ADDR_MSR_PRI;
    wire [9:0] a_ctl = addr_secondary ? ADDR_CTL_SEC : ADDR_CTL_PRI;
    wire [9:0] a_dir = addr_secondary ? ADDR_DIR_SEC : ADDR_DIR_PRI;

    // Writes and reads to one address hit different registers
    wire wr_dor  = io_wr && (io_addr == a_dor);
    wire wr_ctl  = io_wr && (io_addr == a_ctl);
    wire wr_rate = io_wr && (io_addr == a_dir);
    wire rd_msr  = io_rd && (io_addr == a_msr);
    wire rd_alt  = io_rd && (io_addr == a_ctl);
    wire rd_dir  = io_rd && (io_addr == a_dir);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    ////////////////////////////////////////////////////////////////////////////

    logic [7:0]    dor_reg;        // Digital output, reserved bits kept zero
    logic          top_head_select_enable_reg;      // Fourth head select enable
    logic          disk_rst_reg;   // Fixed disk reset bit
    logic          mask_reg;       // IRQ14 mask
    logic          pending_reg;    // Pending hard disk interrupt
    rate_code_t    rate_reg;       // Floppy rate code
    logic [FLOPPY_CTRL_RESET_N_CNT_W-1:0] floppy_ctrl_reset_n_cnt_reg; // Floppy reset stretch counter

    // Only documented bits are stored; reserved bits never reach logic
    wire [7:0] dor_mask = (8'h01 << DOR_UNIT) | (8'h01 << DOR_RESET_N)
                        | (8'h01 << DOR_GATE) | (8'h01 << DOR_MOTOR_A)
                        | (8'h01 << DOR_MOTOR_B);

    // Digital output register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dor_reg <= DOR_RESET_VAL;
        else if (wr_dor)
            dor_reg <= io_wdata & dor_mask;
    end

    // Fixed disk control; mask set by master reset
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            top_head_select_enable_reg    <= 1'b0;
            disk_rst_reg <= 1'b0;
            mask_reg     <= MASK_RESET_VAL;
        end
        else if (wr_ctl)
        begin
            top_head_select_enable_reg    <= io_wdata[CTL_TOP_HEAD_SELECT_ENABLE];
            disk_rst_reg <= io_wdata[CTL_RESET];
            mask_reg     <= io_wdata[CTL_MASK];
        end
    end

    // Rate register, defaults to fastest MFM
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rate_reg <= RATE_500_MFM;
        else if (wr_rate)
            rate_reg <= rate_code_t'(io_wdata[1:0]);
    end

    // Pending interrupt survives masking; event beats clear
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pending_reg <= 1'b0;
        else if (disk_irq_event)
            pending_reg <= 1'b1;
        else if (disk_irq_clear)
            pending_reg <= 1'b0;
    end

    // Floppy reset held at least the minimum time even after release write
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            floppy_ctrl_reset_n_cnt_reg <= FLOPPY_CTRL_RESET_N_CNT_W'(FLOPPY_CTRL_RESET_N_CYCLES);
        else if (!dor_reg[DOR_RESET_N])
            floppy_ctrl_reset_n_cnt_reg <= FLOPPY_CTRL_RESET_N_CNT_W'(FLOPPY_CTRL_RESET_N_CYCLES);
        else if (floppy_ctrl_reset_n_cnt_reg != '0)
            floppy_ctrl_reset_n_cnt_reg <= floppy_ctrl_reset_n_cnt_reg - FLOPPY_CTRL_RESET_N_CNT_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    ////////////////////////////////////////////////////////////////////////////

    // Floppy side
    assign floppy_ctrl_reset_n = dor_reg[DOR_RESET_N] && (floppy_ctrl_reset_n_cnt_reg == '0);
    assign floppy_motor_a_on   = dor_reg[DOR_MOTOR_A];
    assign floppy_motor_b_on   = dor_reg[DOR_MOTOR_B];
    assign floppy_sel_a = !dor_reg[DOR_UNIT] && dor_reg[DOR_MOTOR_A];
    assign floppy_sel_b =  dor_reg[DOR_UNIT] && dor_reg[DOR_MOTOR_B];
    assign floppy_rate  = rate_reg;

    // Request drivers enabled only when gate is set
    assign floppy_irq_out  = dor_reg[DOR_GATE] && floppy_irq_req;
    assign floppy_dma_out  = dor_reg[DOR_GATE] && floppy_dma_req;
    assign floppy_irq_oe_n = !dor_reg[DOR_GATE];
    assign floppy_dma_oe_n = !dor_reg[DOR_GATE];

    // Hard disk side; firmware may keep the board reset off
    assign formatter_reset        = disk_rst_reg;
    assign board_reset_out        = disk_rst_reg && !reset_out_disable;
    assign top_head_select_enable = top_head_select_enable_reg;
    assign host_irq14             = pending_reg && !mask_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Read data
    ////////////////////////////////////////////////////////////////////////////

    // Main floppy status, bits 3 and 2 read zero
    wire [7:0] msr_val = {floppy_status.port_ready,
                          floppy_status.transfer_direction,
                          floppy_status.exec_phase,
                          floppy_status.cmd_active,
                          2'b00,
                          floppy_status.unit_b_seeking,
                          floppy_status.unit_a_seeking};

    // Alternate status straight from formatter
    wire [7:0] alt_val = disk_status;

    // Digital input mirrors live lines
    wire [7:0] dir_val = {media_change_raw, drive_lines};

    // Registered read data, zero for unmapped addresses
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            io_rdata    <= 8'h00;
            io_rdata_en <= 1'b0;
        end
        else
        begin
            io_rdata    <= rd_msr ? msr_val : rd_alt ? alt_val : rd_dir ? dir_val : 8'h00;
            io_rdata_en <= rd_msr || rd_alt || rd_dir;
        end
    end

endmodule : disk_ctrl_status_ports

//--- sim/ports_checker.sv
// Checker of the disk port bank: bus replies and control outputs.
// Sees only the bank's ports; one clock, asynchronous low reset.
`timescale 1ns/1ps
module ports_checker
    import disk_ports_pkg::*;
(
    input wire logic       clk, rst_n, io_rd, io_wr, io_rdata_en, addr_secondary,
    input wire logic [9:0] io_addr,
    input wire logic [7:0] io_wdata, io_rdata,
    input wire logic       floppy_irq_req, floppy_irq_out, floppy_irq_oe_n,
    input wire logic       floppy_dma_req, floppy_dma_out, floppy_dma_oe_n,
    input wire logic       floppy_sel_a, floppy_sel_b, floppy_motor_a_on, floppy_motor_b_on,
    input wire logic       floppy_ctrl_reset_n, formatter_reset, board_reset_out,
    input wire logic       reset_out_disable, host_irq14,
    input wire floppy_status_t floppy_status,
    input wire rate_code_t floppy_rate
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Addresses of the set the jumper picks
    wire [9:0] a_dor = addr_secondary ? ADDR_DOR_SEC : ADDR_DOR_PRI;
    wire [9:0] a_msr = addr_secondary ? ADDR_MSR_SEC : ADDR_MSR_PRI;
    wire [9:0] a_ctl = addr_secondary ? ADDR_CTL_SEC : ADDR_CTL_PRI;
    wire [9:0] a_dir = addr_secondary ? ADDR_DIR_SEC : ADDR_DIR_PRI;
    // Readable ports; the output register is write-only, so it reads nothing
    wire hit = io_addr == a_msr || io_addr == a_ctl || io_addr == a_dir;
    wire [7:0] msr_exp = {floppy_status[5:2], 2'b00, floppy_status[1:0]};
    wire [1:0] sel_exp = {io_wdata[0] & io_wdata[5], !io_wdata[0] & io_wdata[4]};
    sequence wr_at(logic [9:0] a);
        io_wr && io_addr == a;
    endsequence
    AST_RD_REPLY: assert property (io_rd |=> io_rdata_en == $past(hit))
        else $error("read reply flag wrong");
    AST_REFUSED: assert property (io_rd && !hit |=> io_rdata == 8'h00)
        else $error("refused read gave data");
    AST_MSR: assert property (io_rd && io_addr == a_msr |=> io_rdata == $past(msr_exp))
        else $error("floppy status read wrong");
    AST_MOTOR: assert property (
        wr_at(a_dor) |=> {floppy_motor_b_on, floppy_motor_a_on} == $past(io_wdata[5:4]))
        else $error("motor bits wrong");
    AST_SELECT: assert property (
        wr_at(a_dor) |=> {floppy_sel_b, floppy_sel_a} == $past(sel_exp))
        else $error("drive select wrong");
    AST_GATE: assert property (
        floppy_irq_out == (!floppy_irq_oe_n && floppy_irq_req) && floppy_dma_out ==
        (!floppy_dma_oe_n && floppy_dma_req) && floppy_dma_oe_n == floppy_irq_oe_n)
        else $error("request gating wrong");
    AST_FLOPPY_RST: assert property (
        wr_at(a_dor) ##0 !io_wdata[2] |=> !floppy_ctrl_reset_n)
        else $error("floppy reset not held");
    AST_RATE: assert property (wr_at(a_dir) |=> floppy_rate == $past(io_wdata[1:0]))
        else $error("rate code wrong");
    AST_FMT_RST: assert property (wr_at(a_ctl) |=> formatter_reset == $past(io_wdata[2]))
        else $error("formatter reset wrong");
    AST_BOARD_RST: assert property (
        board_reset_out == (formatter_reset && !reset_out_disable))
        else $error("board reset wrong");
    AST_MASK: assert property (wr_at(a_ctl) ##0 io_wdata[1] |=> !host_irq14)
        else $error("masked interrupt seen");
endmodule : ports_checker

//--- sim/host_model.sv
// Host processor model: single-byte I/O cycles on the low lane.
// Assumes the bank takes a strobe at a rising edge and replies one cycle on.
`timescale 1ns/1ps
module host_model (
    input  wire logic       clk,
    output logic [9:0]      io_addr,
    output logic            io_rd,
    output logic            io_wr,
    output logic [7:0]      io_wdata,
    input  wire logic [7:0] io_rdata,
    input  wire logic       io_rdata_en
);
    initial {io_addr, io_rd, io_wr, io_wdata} = 20'h0;
    // Byte write; the lane is inverted once released so stale data cannot pass
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr  <= a;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk);
        io_wr    <= 1'b0;
        io_wdata <= ~d;
    endtask : wr
    // Byte read; reply is taken once the strobe edge has landed
    task automatic rd(input logic [9:0] a, output logic [8:0] r);
        @(posedge clk);
        io_addr <= a;
        io_rd   <= 1'b1;
        @(posedge clk);
        io_rd   <= 1'b0;
        #1 r = {io_rdata_en, io_rdata};
    endtask : rd
endmodule : host_model

//--- sim/tb.sv
// Bench of the disk port bank: write table, then reads, interrupts, resets.
// Needs the package, the host model and the checker compiled first.
`timescale 1ns/1ps
module tb;
    import disk_ports_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, addr_secondary = 1'b0, reset_out_disable = 1'b0;
    logic floppy_irq_req = 1'b1, floppy_dma_req = 1'b1, media_change_raw = 1'b1;
    logic disk_irq_event = 1'b0, disk_irq_clear = 1'b0;
    floppy_status_t floppy_status = 6'b101011;
    disk_status_t   disk_status   = 8'h5a;
    drive_lines_t   drive_lines   = 7'b1011001;
    logic [9:0] io_addr;
    logic [7:0] io_wdata, io_rdata;
    logic io_rd, io_wr, io_rdata_en, floppy_irq_out, floppy_dma_out, floppy_irq_oe_n;
    logic floppy_dma_oe_n, floppy_ctrl_reset_n, floppy_motor_a_on, floppy_motor_b_on;
    logic floppy_sel_a, floppy_sel_b, formatter_reset, board_reset_out;
    logic top_head_select_enable, host_irq14;
    rate_code_t floppy_rate;
    int n_fail = 0, tests_run = 0;
    logic [8:0] r;
    // Rows: address, data, expected {motors, selects, oe_n, head3 enable, rate}
    typedef struct packed { logic [9:0] a; logic [7:0] d; logic [7:0] e; } row_t;
    row_t rows [10] = '{'{10'h3f2, 8'h10, 8'h58}, '{10'h3f2, 8'h21, 8'ha8},
        '{10'h3f2, 8'h11, 8'h48}, '{10'h3f2, 8'hc8, 8'h00}, '{10'h3f7, 8'h01, 8'h01},
        '{10'h3f7, 8'hfe, 8'h02}, '{10'h3f7, 8'h03, 8'h03}, '{10'h3f6, 8'h08, 8'h07},
        '{10'h3f7, 8'h00, 8'h04}, '{10'h372, 8'h30, 8'h04}};
    wire [7:0] obs = {floppy_motor_b_on, floppy_motor_a_on, floppy_sel_b, floppy_sel_a,
        floppy_irq_oe_n, top_head_select_enable, floppy_rate};
    disk_ctrl_status_ports dut (.*);
    host_model host (.clk, .io_addr, .io_rd, .io_wr, .io_wdata, .io_rdata, .io_rdata_en);
    ////////////////////////////////////////////////////////////////
    // Wide enough for the largest packed group of outputs compared at once
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize
    initial forever #25 clk = ~clk;
    // Hang guard; the run needs well under this many cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk({obs, floppy_ctrl_reset_n, host_irq14, floppy_irq_out}, 11'h040);
        for (int i = 0; i < 10; i++)
        begin
            host.wr(rows[i].a, rows[i].d);
            #1 chk(obs, rows[i].e);
        end
        chk({floppy_irq_out, floppy_dma_out, floppy_dma_oe_n}, 3'b110);
        host.rd(ADDR_MSR_PRI, r);
        chk(r, 9'h1a3);
        @(posedge clk) floppy_status <= 6'b010100;
        host.rd(ADDR_MSR_PRI, r);
        chk(r, 9'h150);
        host.rd(ADDR_CTL_PRI, r);
        chk(r, 9'h15a);
        host.rd(ADDR_DIR_PRI, r);
        chk(r, 9'h1d9);
        host.rd(ADDR_DOR_PRI, r);
        chk(r, 9'h000);
        host.rd(10'h3f5, r);
        chk(r, 9'h000);
        // A request raised while masked must show once the mask drops
        host.wr(ADDR_CTL_PRI, 8'h0a);
        @(posedge clk) disk_irq_event <= 1'b1;
        @(posedge clk) disk_irq_event <= 1'b0;
        #1 chk(host_irq14, 1'b0);
        host.wr(ADDR_CTL_PRI, 8'h08);
        #1 chk(host_irq14, 1'b1);
        @(posedge clk) disk_irq_clear <= 1'b1;
        @(posedge clk) disk_irq_clear <= 1'b0;
        #1 chk(host_irq14, 1'b0);
        host.wr(ADDR_DOR_PRI, 8'h1c);
        repeat (10) @(posedge clk);
        #1 chk(floppy_ctrl_reset_n, 1'b0);
        repeat (70) @(posedge clk);
        #1 chk(floppy_ctrl_reset_n, 1'b1);
        host.wr(ADDR_DOR_PRI, 8'h18);
        #1 chk(floppy_ctrl_reset_n, 1'b0);
        host.wr(ADDR_CTL_PRI, 8'h04);
        #1 chk({formatter_reset, board_reset_out}, 2'b11);
        repeat (100) @(posedge clk);
        @(posedge clk) reset_out_disable <= 1'b1;
        #1 chk({formatter_reset, board_reset_out}, 2'b10);
        host.wr(ADDR_CTL_PRI, 8'h00);
        #1 chk({formatter_reset, board_reset_out}, 2'b00);
        @(posedge clk) addr_secondary <= 1'b1;
        host.wr(ADDR_DIR_SEC, 8'h02);
        #1 chk(floppy_rate, RATE_250_MFM);
        host.rd(ADDR_MSR_PRI, r);
        chk(r, 9'h000);
        // Leave a request pending, unmasked, so the reset has something to clear
        @(posedge clk) disk_irq_event <= 1'b1;
        @(posedge clk) disk_irq_event <= 1'b0;
        #1 chk(host_irq14, 1'b1);
        // Second reset in mid-run: pending is dropped, mask comes back on
        @(posedge clk) rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1 chk({host_irq14, floppy_rate}, 3'b000);
        host.wr(ADDR_CTL_SEC, 8'h00);
        #1 chk(host_irq14, 1'b0);
        @(posedge clk) disk_irq_event <= 1'b1;
        @(posedge clk) disk_irq_event <= 1'b0;
        #1 chk(host_irq14, 1'b1);
        summarize();
    end
endmodule : tb
bind disk_ctrl_status_ports ports_checker chk_i (.*);
